// ===== ast_pkg.sv
// shared constants, types and helpers for the async serial transceiver
package ast_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_DATA = 12'h000;
  localparam logic [11:0] ADDR_RSR = 12'h004;
  localparam logic [11:0] ADDR_FLAG = 12'h018;
  localparam logic [11:0] ADDR_IBRD = 12'h024;
  localparam logic [11:0] ADDR_FBRD = 12'h028;
  localparam logic [11:0] ADDR_LCRH = 12'h02C;
  localparam logic [11:0] ADDR_CTL = 12'h030;
  localparam logic [11:0] ADDR_IFLS = 12'h034;
  localparam logic [11:0] ADDR_IM = 12'h038;
  localparam logic [11:0] ADDR_RIS = 12'h03C;
  localparam logic [11:0] ADDR_MIS = 12'h040;
  localparam logic [11:0] ADDR_ICR = 12'h044;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LCR_BRK = 0;   // force line low
  localparam int LCR_PEN = 1;   // parity enable
  localparam int LCR_EPS = 2;   // even parity select
  localparam int LCR_STP2 = 3;  // two stop bits
  localparam int LCR_FEN = 4;   // fifo enable
  localparam int LCR_WLEN = 5;  // word length, bits 6:5
  localparam int LCR_SPS = 7;   // stick parity
  localparam int CTL_EN = 0;    // port_global_enable
  localparam int CTL_LBE = 7;   // internal loopback
  localparam int CTL_TXE = 8;   // tx_path_enable
  localparam int CTL_RXE = 9;   // rx_path_enable
  localparam int IFLS_RX = 3;   // rx level at 5:3, tx level at 2:0
  localparam int FR_BUSY = 3;
  localparam int FR_RXFE = 4;
  localparam int FR_TXFF = 5;
  localparam int FR_RXFF = 6;
  localparam int FR_TXFE = 7;
  localparam int ERR_FE = 0;    // status bits, also entry bits 11:8
  localparam int ERR_PE = 1;
  localparam int ERR_BE = 2;
  localparam int ERR_OE = 3;
  localparam int INT_RX = 4;
  localparam int INT_TX = 5;
  localparam int INT_RT = 6;
  localparam int INT_FE = 7;
  localparam int INT_PE = 8;
  localparam int INT_BE = 9;
  localparam int INT_OE = 10;
  localparam int INT_W = 11;
  // ----------------------------------------------------------------
  // reset values, masks, sizes and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] CTL_RESET = 16'h0300;
  localparam logic [15:0] CTL_MASK = 16'h0381;
  localparam logic [5:0] IFLS_RESET = 6'h12;
  localparam logic [10:0] INT_MASK = 11'h7F0;
  localparam int FIFO_DEPTH = 16;
  localparam logic [3:0] TICK_LAST = 4'hF;   // sixteen ticks per bit
  localparam logic [3:0] TICK_START = 4'h7;  // eighth tick
  localparam logic [9:0] RT_TICKS = 10'h200; // 32 idle bit times
  typedef enum logic [2:0] {
    FR_IDLE = 3'h0, FR_START = 3'h1, FR_DATA = 3'h2,
    FR_PARITY = 3'h3, FR_STOP = 3'h4
  } ast_frame_t;
  // fifo trigger level in entries: 1/8, 1/4, 1/2, 3/4, 7/8 of 16
  function automatic logic [4:0] ast_level(input logic [2:0] sel);
    case (sel)
      3'h0: ast_level = 5'h02;
      3'h1: ast_level = 5'h04;
      3'h3: ast_level = 5'h0C;
      3'h4: ast_level = 5'h0E;
      default: ast_level = 5'h08;
    endcase
  endfunction
endpackage

// ===== ast_fifo.sv
// sixteen-entry flip-flop fifo with a one-entry holding mode
`timescale 1ns/1ps
module ast_fifo
  import ast_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic deep,
  input wire logic push,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic [4:0] count,
  output logic full,
  output logic empty
);
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][WIDTH-1:0] mem; // storage
    logic [3:0] wp;                        // write index
    logic [3:0] rp;                        // read index
    logic [4:0] cnt;                       // entries held
  } ast_fifo_state_t;
  ast_fifo_state_t s_reg, s_next;
  logic push_ok, pop_ok;

  // shallow mode holds a single entry like a plain holding register
  assign full = s_reg.cnt >= (deep ? 5'h10 : 5'h01);
  assign empty = s_reg.cnt == 5'h00;
  assign head = s_reg.mem[s_reg.rp];
  assign count = s_reg.cnt;
  assign push_ok = push && !full;
  assign pop_ok = pop && !empty;

  // next state: write at wp, read at rp
  always_comb begin
    s_next = s_reg;
    if (push_ok) begin
      s_next.mem[s_reg.wp] = wdata;
      s_next.wp = s_reg.wp + 4'h1;
    end
    if (pop_ok) begin
      s_next.rp = s_reg.rp + 4'h1;
    end
    if (push_ok && !pop_ok) begin
      s_next.cnt = s_reg.cnt + 5'h01;
    end else if (pop_ok && !push_ok) begin
      s_next.cnt = s_reg.cnt - 5'h01;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule // ast_fifo

// ===== ast_baud_gen.sv
// fractional divider making the sixteen-times oversample tick
`timescale 1ns/1ps
module ast_baud_gen (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [15:0] div_whole,
  input wire logic [5:0] div_frac,
  output logic tick
);
  typedef struct packed {
    logic [15:0] cnt;  // clocks in current tick period
    logic [5:0] acc;   // fraction accumulator in 64ths
    logic extra;       // stretch this period by one clock
    logic tick;        // registered tick
  } ast_baud_state_t;
  ast_baud_state_t s_reg, s_next;
  logic [6:0] acc_sum;

  assign acc_sum = {1'b0, s_reg.acc} + {1'b0, div_frac};
  assign tick = s_reg.tick;

  // period is whole or whole+1 clocks so the mean is whole + frac/64
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (div_whole == 16'h0000) begin
      // zero divisor stops the generator
      s_next.cnt = 16'h0000;
    end else if ({1'b0, s_reg.cnt} + 17'h00001 >=
                 {1'b0, div_whole} + {16'h0000, s_reg.extra}) begin
      s_next.tick = 1'b1;
      s_next.cnt = 16'h0000;
      s_next.acc = acc_sum[5:0];
      s_next.extra = acc_sum[6];
    end else begin
      s_next.cnt = s_reg.cnt + 16'h0001;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule // ast_baud_gen

// ===== ast_transceiver.sv
// async serial transceiver: registers, transmitter and receiver
`timescale 1ns/1ps
// How it works
// - tx and rx enables, both set after reset
// - disabling finishes the current character first
// - start, data lsb first, parity, stop
// - rx errors stored with each character
// - 16-bit whole plus 6-bit fraction divisor
// - divisor is clock over sixteen times baud
// - oversample tick; sixteen ticks per bit
// - 30-bit config loads on line-control write
// - sixteen-deep fifos, rx carries four status
// - tx runs while fifo holds data
// - busy set when tx fifo non-empty
// - busy clears after last stop bit
// - start edge, sample at eighth tick
// - high at eighth tick is false start
// - data sampled every sixteenth tick
// - parity checked, low stop is framing error
// - five to eight data bits
// - even, odd, stick or no parity
// - one or two stop bits
// - fifos one deep until fifo enable
// - trigger levels, both reset to half
// - maskable events ored, write-one clears
module ast_transceiver
  import ast_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [11:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic port0_serial_in,
  output logic port0_serial_out,
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ibrd;        // divisor_integer_reg
    logic [5:0] fbrd;         // divisor_fraction_reg
    logic [29:0] line_cfg;    // whole, fraction, line_control_reg
    logic [15:0] ctl;         // port_control_reg
    logic [5:0] ifls;         // fifo_level_select_reg
    logic [INT_W-1:0] im;     // interrupt mask
    logic [INT_W-1:0] ris;    // raw interrupt status
    logic [3:0] rsr;          // receive_error_status_reg
    logic rx_s1;              // synchroniser stage one
    logic rx_s2;              // synchroniser stage two
    logic rx_prev;            // line one cycle back
    ast_frame_t tx_st;
    logic [3:0] tx_tick;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic tx_par;
    ast_frame_t rx_st;
    logic [3:0] rx_tick;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_par;
    logic rx_low;             // every sample so far was low
    logic ovr_pend;           // overrun to tag on next entry
    logic [9:0] rt_cnt;       // idle ticks with rx data waiting
    logic rx_lvl_d;
    logic tx_lvl_d;
    logic txd;
    logic irq;
    logic [31:0] rdata;
  } ast_state_t;
  ast_state_t s_reg, s_next;

  logic tick;                 // oversample_tick
  logic [7:0] lcr;            // live line settings
  logic rxd;                  // receive line after sync/loopback
  logic busy;
  logic [2:0] last_bit;       // index of final data bit
  logic tx_push, tx_pop, rx_push, rx_pop;
  logic [11:0] rx_entry;
  logic [7:0] tx_head;
  logic [11:0] rx_head;
  logic [4:0] tx_count, rx_count;
  logic tx_full, tx_empty, rx_full, rx_empty;
  logic [3:0] err_set;
  logic [INT_W-1:0] int_set;
  logic rx_lvl, tx_lvl;

  // parity bit for the data bits in use
  function automatic logic par_bit(input logic [7:0] d,
                                   input logic [7:0] l);
    logic [7:0] m;
    m = d & (8'hFF >> (2'h3 - l[LCR_WLEN+:2]));
    if (l[LCR_SPS]) begin
      par_bit = ~l[LCR_EPS];
    end else begin
      par_bit = l[LCR_EPS] ? ^m : ~^m;
    end
  endfunction

  // ----------------------------------------------------------------
  // datapath pieces
  // ----------------------------------------------------------------
  assign lcr = s_reg.line_cfg[7:0];
  assign last_bit = {1'b1, s_reg.line_cfg[LCR_WLEN+:2]};
  // loopback returns the line we drive; s1 feeds s2 only
  assign rxd = s_reg.ctl[CTL_LBE] ? s_reg.txd : s_reg.rx_s2;
  assign busy = !tx_empty || (s_reg.tx_st != FR_IDLE);
  assign rx_lvl = rx_count >= (lcr[LCR_FEN] ?
                  ast_level(s_reg.ifls[IFLS_RX+:3]) : 5'h01);
  assign tx_lvl = tx_count <= (lcr[LCR_FEN] ?
                  ast_level(s_reg.ifls[2:0]) : 5'h00);
  assign bus_rdata = s_reg.rdata;
  assign port0_serial_out = s_reg.txd;
  assign irq = s_reg.irq;

  // divisor comes from the loaded 30-bit copy only
  ast_baud_gen u_baud (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .div_whole(s_reg.line_cfg[29:14]),
    .div_frac(s_reg.line_cfg[13:8]),
    .tick(tick)
  );

  ast_fifo #(.WIDTH(8)) u_tx_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .deep(lcr[LCR_FEN]),
    .push(tx_push),
    .wdata(bus_wdata[7:0]),
    .pop(tx_pop),
    .head(tx_head),
    .count(tx_count),
    .full(tx_full),
    .empty(tx_empty)
  );

  ast_fifo #(.WIDTH(12)) u_rx_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .deep(lcr[LCR_FEN]),
    .push(rx_push),
    .wdata(rx_entry),
    .pop(rx_pop),
    .head(rx_head),
    .count(rx_count),
    .full(rx_full),
    .empty(rx_empty)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_entry = '0;
    err_set = 4'h0;
    int_set = '0;
    s_next.rx_s1 = port0_serial_in;
    s_next.rx_s2 = s_reg.rx_s1;
    s_next.rx_prev = rxd;

    // transmitter: enables only gate the start of a character
    unique case (s_reg.tx_st)
      FR_IDLE: begin
        if (!tx_empty && s_reg.ctl[CTL_EN] && s_reg.ctl[CTL_TXE]) begin
          tx_pop = 1'b1;
          s_next.tx_shift = tx_head;
          s_next.tx_par = par_bit(tx_head, lcr);
          s_next.tx_tick = 4'h0;
          s_next.tx_st = FR_START;
        end
      end
      FR_START, FR_DATA, FR_PARITY, FR_STOP: begin
        if (tick) begin
          s_next.tx_tick = s_reg.tx_tick + 4'h1;
          if (s_reg.tx_tick == TICK_LAST) begin
            unique case (s_reg.tx_st)
              FR_START: begin
                s_next.tx_bit = 3'h0;
                s_next.tx_st = FR_DATA;
              end
              FR_DATA: begin
                // lsb leaves first
                s_next.tx_shift = {1'b0, s_reg.tx_shift[7:1]};
                s_next.tx_bit = s_reg.tx_bit + 3'h1;
                if (s_reg.tx_bit == last_bit) begin
                  s_next.tx_bit = 3'h0;
                  s_next.tx_st = lcr[LCR_PEN] ? FR_PARITY : FR_STOP;
                end
              end
              FR_PARITY: begin
                s_next.tx_bit = 3'h0;
                s_next.tx_st = FR_STOP;
              end
              default: begin
                // second stop bit when configured
                if (lcr[LCR_STP2] && s_reg.tx_bit == 3'h0) begin
                  s_next.tx_bit = 3'h1;
                end else begin
                  s_next.tx_st = FR_IDLE;
                end
              end
            endcase
          end
        end
      end
      default: s_next.tx_st = FR_IDLE;
    endcase

    // line level follows the next transmitter state
    unique case (s_next.tx_st)
      FR_START: s_next.txd = 1'b0;
      FR_DATA: s_next.txd = s_next.tx_shift[0];
      FR_PARITY: s_next.txd = s_next.tx_par;
      default: s_next.txd = 1'b1;
    endcase
    if (lcr[LCR_BRK]) begin
      s_next.txd = 1'b0;
    end

    // receiver
    unique case (s_reg.rx_st)
      FR_IDLE: begin
        s_next.rx_tick = 4'h0;
        // falling edge only, so a held break does not restart
        if (s_reg.ctl[CTL_EN] && s_reg.ctl[CTL_RXE] && s_reg.rx_prev &&
            !rxd) begin
          s_next.rx_st = FR_START;
        end
      end
      FR_START: begin
        if (tick) begin
          s_next.rx_tick = s_reg.rx_tick + 4'h1;
          if (s_reg.rx_tick == TICK_START) begin
            s_next.rx_tick = 4'h0;
            s_next.rx_bit = 3'h0;
            s_next.rx_shift = 8'h00;
            s_next.rx_low = 1'b1;
            // glitch shorter than half a bit is dropped
            s_next.rx_st = rxd ? FR_IDLE : FR_DATA;
          end
        end
      end
      FR_DATA, FR_PARITY, FR_STOP: begin
        if (tick) begin
          s_next.rx_tick = s_reg.rx_tick + 4'h1;
          if (s_reg.rx_tick == TICK_LAST) begin
            s_next.rx_low = s_reg.rx_low && !rxd;
            unique case (s_reg.rx_st)
              FR_DATA: begin
                s_next.rx_shift[s_reg.rx_bit] = rxd;
                s_next.rx_bit = s_reg.rx_bit + 3'h1;
                if (s_reg.rx_bit == last_bit) begin
                  s_next.rx_st = lcr[LCR_PEN] ? FR_PARITY : FR_STOP;
                end
              end
              FR_PARITY: begin
                s_next.rx_par = rxd;
                s_next.rx_st = FR_STOP;
              end
              default: begin
                // stop sample closes the character
                err_set[ERR_FE] = !rxd;
                err_set[ERR_BE] = s_reg.rx_low && !rxd;
                err_set[ERR_PE] = lcr[LCR_PEN] &&
                  (s_reg.rx_par != par_bit(s_reg.rx_shift, lcr));
                rx_entry = {s_reg.ovr_pend, err_set[2:0],
                            s_reg.rx_shift};
                if (rx_full) begin
                  err_set[ERR_OE] = 1'b1;
                  s_next.ovr_pend = 1'b1;
                end else begin
                  rx_push = 1'b1;
                  s_next.ovr_pend = 1'b0;
                end
                s_next.rx_st = FR_IDLE;
              end
            endcase
          end
        end
      end
      default: s_next.rx_st = FR_IDLE;
    endcase

    // bus access: reads answer one cycle later
    if (bus_rd) begin
      unique case (bus_addr)
        ADDR_DATA: begin
          s_next.rdata = {20'h00000, rx_head};
          rx_pop = !rx_empty;
        end
        ADDR_RSR: s_next.rdata = {28'h0000000, s_reg.rsr};
        ADDR_FLAG: s_next.rdata = {24'h000000, tx_empty, rx_full,
                                   tx_full, rx_empty, busy, 3'h0};
        ADDR_IBRD: s_next.rdata = {16'h0000, s_reg.ibrd};
        ADDR_FBRD: s_next.rdata = {26'h0000000, s_reg.fbrd};
        ADDR_LCRH: s_next.rdata = {24'h000000, lcr};
        ADDR_CTL: s_next.rdata = {16'h0000, s_reg.ctl};
        ADDR_IFLS: s_next.rdata = {26'h0000000, s_reg.ifls};
        ADDR_IM: s_next.rdata = {21'h000000, s_reg.im};
        ADDR_RIS: s_next.rdata = {21'h000000, s_reg.ris};
        ADDR_MIS: s_next.rdata = {21'h000000, s_reg.ris & s_reg.im};
        default: s_next.rdata = 32'h00000000;
      endcase
    end
    if (bus_wr) begin
      unique case (bus_addr)
        ADDR_DATA: tx_push = 1'b1;
        ADDR_IBRD: s_next.ibrd = bus_wdata[15:0];
        ADDR_FBRD: s_next.fbrd = bus_wdata[5:0];
        ADDR_LCRH: s_next.line_cfg = {s_reg.ibrd, s_reg.fbrd,
                                      bus_wdata[7:0]};
        ADDR_CTL: s_next.ctl = bus_wdata[15:0] & CTL_MASK;
        ADDR_IFLS: s_next.ifls = bus_wdata[5:0];
        ADDR_IM: s_next.im = bus_wdata[INT_W-1:0] & INT_MASK;
        default: begin
        end
      endcase
    end

    // receive timeout: rx data waiting while the line is quiet
    if (rx_empty || rx_push || rx_pop || s_reg.rx_st != FR_IDLE) begin
      s_next.rt_cnt = 10'h000;
    end else if (tick && s_reg.rt_cnt != RT_TICKS) begin
      s_next.rt_cnt = s_reg.rt_cnt + 10'h001;
    end

    // sticky status; a set in the clearing cycle survives
    s_next.rx_lvl_d = rx_lvl;
    s_next.tx_lvl_d = tx_lvl;
    int_set[INT_RX] = rx_lvl && !s_reg.rx_lvl_d;
    int_set[INT_TX] = tx_lvl && !s_reg.tx_lvl_d;
    int_set[INT_RT] = s_next.rt_cnt == RT_TICKS &&
                      s_reg.rt_cnt != RT_TICKS;
    int_set[INT_FE] = err_set[ERR_FE];
    int_set[INT_PE] = err_set[ERR_PE];
    int_set[INT_BE] = err_set[ERR_BE];
    int_set[INT_OE] = err_set[ERR_OE];
    s_next.rsr = ((bus_wr && bus_addr == ADDR_RSR) ? 4'h0 : s_reg.rsr) |
                 err_set;
    s_next.ris = (s_reg.ris & ~((bus_wr && bus_addr == ADDR_ICR) ?
                 bus_wdata[INT_W-1:0] : '0)) | int_set;
    s_next.irq = |(s_next.ris & s_next.im);
  end

  // ----------------------------------------------------------------
  // state register, synchronous reset
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.ctl <= CTL_RESET;
      s_reg.ifls <= IFLS_RESET;
      s_reg.rx_s1 <= 1'b1;
      s_reg.rx_s2 <= 1'b1;
      s_reg.rx_prev <= 1'b1;
      s_reg.txd <= 1'b1;
      // empty tx fifo already sits at its level, so no false edge
      s_reg.tx_lvl_d <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_tx_busy_rise: assert property (tx_push && !tx_full |=> busy)
    else $error("busy not set after tx write");
  a_tx_busy_fall: assert property ($fell(busy) |->
    $past(s_reg.tx_st) == FR_STOP && port0_serial_out)
    else $error("busy dropped before stop bit end");
  a_tx_start_low: assert property (s_reg.tx_st == FR_START &&
    !lcr[LCR_BRK] |-> !port0_serial_out)
    else $error("start bit not low");
  a_tx_stop_high: assert property (s_reg.tx_st == FR_STOP &&
    !lcr[LCR_BRK] |-> port0_serial_out)
    else $error("stop bit not high");
  a_rx_false_start: assert property (s_reg.rx_st == FR_START && tick &&
    s_reg.rx_tick == TICK_START && rxd |=> s_reg.rx_st == FR_IDLE)
    else $error("false start not dropped");
  a_rx_bit_step: assert property (s_reg.rx_st == FR_DATA && tick &&
    s_reg.rx_tick == TICK_LAST |=> s_reg.rx_tick == 4'h0 &&
    (s_reg.rx_st != FR_DATA || s_reg.rx_bit == $past(s_reg.rx_bit) + 3'h1))
    else $error("rx bit step wrong");
  a_cfg_load: assert property (bus_wr && bus_addr == ADDR_LCRH |=>
    s_reg.line_cfg == {$past(s_reg.ibrd), $past(s_reg.fbrd),
                       $past(bus_wdata[7:0])})
    else $error("config copy not loaded");
  a_cfg_hold: assert property (!(bus_wr && bus_addr == ADDR_LCRH) |=>
    $stable(s_reg.line_cfg))
    else $error("config copy changed without write");
  a_rx_overrun: assert property (rx_full && s_reg.rx_st == FR_STOP && tick &&
    s_reg.rx_tick == TICK_LAST |-> !rx_push ##1 s_reg.rsr[ERR_OE])
    else $error("overrun not flagged");
  a_irq_or: assert property (irq == |(s_reg.ris & s_reg.im))
    else $error("interrupt line mismatch");

  c_tx_frame: cover property (s_reg.tx_st == FR_STOP ##1
    s_reg.tx_st == FR_IDLE);
  c_rx_push: cover property (rx_push);
  c_rx_false: cover property (s_reg.rx_st == FR_START ##1
    s_reg.rx_st == FR_IDLE);
  c_rx_break: cover property (rx_push && rx_entry[8+ERR_BE]);
endmodule // ast_transceiver

// ===== ast_peer.sv
// remote serial peer model for the transceiver bench
`timescale 1ns/1ps
module ast_peer (
  input wire logic sys_clk,
  input wire logic line_in,
  output logic line_out
);
  // -----------------
  // peer state
  // -----------------
  logic [7:0] got[$]; // characters heard
  logic [7:0] sh; // receive shift
  initial line_out = 1'b1; // idle high, as a pull-up would
  // one frame at sixteen clocks a bit; stp=0 breaks the stop
  task automatic send(input logic [7:0] d, input logic stp);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    @(posedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (16) @(posedge sys_clk);
    end
    line_out <= 1'b1;
    @(posedge sys_clk); // idle cycle between frames
  endtask
  // listen: mid-bit samples, lsb first, stop must be high
  always begin
    @(negedge line_in);
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge sys_clk);
      sh[i] = line_in;
    end
    repeat (16) @(posedge sys_clk);
    if (line_in) got.push_back(sh);
  end
endmodule // ast_peer

// ===== tb.sv
// self-checking bench for the async serial transceiver
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("mismatch at %0t got %h want %h", $time, a, e); end end
module tb;
  import ast_pkg::*;
  logic sys_clk, resetn, bus_wr, bus_rd, tx_line, rx_line, irq;
  logic [11:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata, v;
  int errors = 0, checks_done = 0, cyc = 0;
  ast_transceiver ast_transceiver_inst (.sys_clk(sys_clk),
    .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .port0_serial_in(rx_line), .port0_serial_out(tx_line), .irq(irq));
  ast_peer ast_peer_inst (.sys_clk(sys_clk), .line_in(tx_line),
    .line_out(rx_line));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // -----------------
  // bus tasks
  // -----------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata; // data stands the cycle after the strobe
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, well above the roughly 1100 cycles needed
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  // -----------------
  // scenarios
  // -----------------
  task automatic t_reset();
    rd(ADDR_CTL); `CHK(v, 32'h0000_0300)
    rd(ADDR_FLAG); `CHK(v, 32'h0000_0090)
    rd(12'h0FC); `CHK(v, 32'h0) // unmapped reads as zero
    rd(ADDR_RIS); `CHK(v, 32'h0)
    $display("reset test done");
  endtask
  task automatic t_tx();
    wr(ADDR_CTL, 32'h0);
    wr(ADDR_IBRD, 32'h1); // tick every clock
    wr(ADDR_FBRD, 32'h0);
    wr(ADDR_LCRH, 32'h70); // 8N1, fifo on
    wr(ADDR_CTL, 32'h301);
    wr(ADDR_DATA, 32'hA5);
    wr(ADDR_DATA, 32'h3C);
    rd(ADDR_FLAG); `CHK(v[FR_BUSY], 1'b1)
    for (int i = 0; i < 400 && v[FR_BUSY] !== 1'b0; i++) rd(ADDR_FLAG);
    `CHK(v[FR_BUSY], 1'b0)
    `CHK(ast_peer_inst.got.size(), 2)
    `CHK(ast_peer_inst.got[0], 8'hA5)
    `CHK(ast_peer_inst.got[1], 8'h3C)
    $display("tx test done");
  endtask
  task automatic t_rx();
    ast_peer_inst.send(8'h5A, 1'b1);
    ast_peer_inst.send(8'hC3, 1'b0);
    repeat (32) @(posedge sys_clk);
    rd(ADDR_DATA); `CHK(v, 32'h0000_005A)
    rd(ADDR_DATA); `CHK(v, 32'h0000_01C3)
    rd(ADDR_FLAG); `CHK(v[FR_RXFE], 1'b1)
    rd(ADDR_RSR); `CHK(v, 32'h0000_0001)
    wr(ADDR_RSR, 32'h0);
    wr(ADDR_IM, 32'h80);
    rd(ADDR_MIS); `CHK(v, 32'h0000_0080)
    `CHK(irq, 1'b1)
    wr(ADDR_ICR, 32'h80);
    rd(ADDR_RIS); `CHK(v, 32'h0)
    `CHK(irq, 1'b0)
    $display("rx test done");
  endtask
  task automatic t_ovr();
    wr(ADDR_CTL, 32'h0);
    wr(ADDR_LCRH, 32'h60); // fifo off, one deep
    wr(ADDR_CTL, 32'h301);
    ast_peer_inst.send(8'hA1, 1'b1);
    ast_peer_inst.send(8'hB2, 1'b1);
    repeat (32) @(posedge sys_clk);
    rd(ADDR_RSR); `CHK(v, 32'h0000_0008)
    rd(ADDR_DATA); `CHK(v, 32'h0000_00A1)
    rd(ADDR_FLAG); `CHK(v[FR_RXFE], 1'b1)
    $display("overrun test done");
  endtask
  initial begin
    resetn = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 12'h000;
    bus_wdata = 32'h0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_tx();
    t_rx();
    t_ovr();
    conclude();
  end
endmodule // tb
